/* File: include/pdgain_consts.svh */
// Purpose: offsets, field positions and reset values of the detector gain bank
// Assumes: 8-bit register port, 7-bit offsets
// Notes: skew low byte address is a parameter default
`ifndef PDGAIN_CONSTS_SVH
`define PDGAIN_CONSTS_SVH

`define PDGAIN_ADDR_W          7
`define PDGAIN_OFF_AUX_GAIN    7'h6C
`define PDGAIN_OFF_MAIN_GAIN   7'h6D
`define PDGAIN_OFF_SKEW_LOW    7'h70
`define PDGAIN_RST_GAIN        8'hC2
`define PDGAIN_RST_SKEW_LOW    8'h00
`define PDGAIN_AUTO_BIT        7
`define PDGAIN_ANALOG_HI       6
`define PDGAIN_ANALOG_LO       4
`define PDGAIN_UNUSED_BIT      3
`define PDGAIN_DIGITAL_HI      2
`define PDGAIN_DIGITAL_LO      0
`define PDGAIN_WMASK_GAIN      8'hF7

`endif

/* File: include/pdgain_pkg.sv */
// Purpose: types of the detector gain bank
// Assumes: constants come from pdgain_consts.svh
// Notes: none
package pdgain_pkg;

   typedef logic [2:0] pdgain_gain_t;

   // locking mode of a loop as seen by its gain selector
   typedef enum logic [1:0] {
      PDGAIN_LOCK_DIGITAL,
      PDGAIN_LOCK_ANALOG_HI,
      PDGAIN_LOCK_ANALOG_LOW
   } pdgain_mode_e;

   typedef struct packed {
      logic         auto_on;
      pdgain_gain_t analog;
      pdgain_gain_t digital;
   } pdgain_field_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } pdgain_req_s;

   typedef struct packed {
      logic [7:0] aux_gain_reg;
      logic [7:0] main_gain_reg;
      logic [7:0] skew_low_reg;
      logic [7:0] rdata_reg;
   } pdgain_state_s;

endpackage : pdgain_pkg

/* File: hw/pdgain_select.sv */
// Purpose: picks the second detector gain for one loop from its register fields
// Assumes: mode and low-rate gain come from the loop and the damping register
// Notes: combinational; valid flags when a programmed gain is in force
`timescale 1ns/1ps
module pdgain_select (
   input  wire pdgain_pkg::pdgain_field_s i_field,
   input  wire pdgain_pkg::pdgain_mode_e  i_mode,
   input  wire pdgain_pkg::pdgain_gain_t  i_low_rate_gain,
   output pdgain_pkg::pdgain_gain_t       o_gain,
   output logic                           o_gain_valid
);
   always_comb begin
      o_gain       = i_field.digital;
      o_gain_valid = 1'b0;
      case (i_mode)
         pdgain_pkg::PDGAIN_LOCK_DIGITAL: begin
            o_gain       = i_field.digital;  // see RL4
            o_gain_valid = 1'b1;
         end
         pdgain_pkg::PDGAIN_LOCK_ANALOG_HI: begin
            o_gain       = i_field.analog;  // see RL3
            o_gain_valid = i_field.auto_on;  // see RL2
         end
         pdgain_pkg::PDGAIN_LOCK_ANALOG_LOW: begin
            o_gain       = i_low_rate_gain;  // see RL6
            o_gain_valid = i_field.auto_on;
         end
         default: begin
            o_gain       = i_field.digital;
            o_gain_valid = 1'b0;
         end
      endcase
   end
endmodule : pdgain_select

/* File: hw/pdgain_bank.sv */
// Purpose: second detector gain registers for both loops plus skew low byte
// Assumes: synchronous register port on i_clk, read data one cycle after i_req.rd
// Notes: only the main loop has a low-rate analog gain input
`timescale 1ns/1ps
`include "pdgain_consts.svh"

// How it works
// RL1: two read/write gain registers, aux and main loops, identical layout
// RL2: bit 7 off disables automatic gain choice; on picks gain by lock mode
// RL3: bits 6:4 give analog feedback gain above 8 kHz, auto mode only
// RL4: bits 2:0 give digital feedback gain, used in digital lock whatever bit 7 holds
// RL5: read/write register holds low byte of output skew control word
// RL6: main loop analog lock at or below 8 kHz uses damping register gain field; aux loop reuses its bits 6:4
// RL7: bit 3 of gain registers ignores writes and reads zero
module pdgain_bank #(
   parameter logic [6:0] SKEW_LOW_ADDR = `PDGAIN_OFF_SKEW_LOW
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_rstn,
   input  wire pdgain_pkg::pdgain_req_s   i_req,
   input  wire pdgain_pkg::pdgain_mode_e  i_aux_mode,
   input  wire pdgain_pkg::pdgain_mode_e  i_main_mode,
   input  wire pdgain_pkg::pdgain_gain_t  i_main_gain_analog_low_rate,
   output logic [7:0]                     o_rdata,
   output logic                           o_hit,
   output logic [7:0]                     o_skew_low,
   output pdgain_pkg::pdgain_field_s      o_aux_field,
   output pdgain_pkg::pdgain_field_s      o_main_field,
   output pdgain_pkg::pdgain_gain_t       o_aux_gain,
   output logic                           o_aux_gain_valid,
   output pdgain_pkg::pdgain_gain_t       o_main_gain,
   output logic                           o_main_gain_valid
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic pdgain_pkg::pdgain_field_s to_field(input logic [7:0] r);
      to_field.auto_on = r[`PDGAIN_AUTO_BIT];
      to_field.analog  = r[`PDGAIN_ANALOG_HI:`PDGAIN_ANALOG_LO];
      to_field.digital = r[`PDGAIN_DIGITAL_HI:`PDGAIN_DIGITAL_LO];
   endfunction : to_field

   pdgain_pkg::pdgain_state_s st_reg;
   pdgain_pkg::pdgain_state_s st_next;
   logic                      hit_aux;
   logic                      hit_main;
   logic                      hit_skew;

   assign hit_aux  = i_req.addr == `PDGAIN_OFF_AUX_GAIN;
   assign hit_main = i_req.addr == `PDGAIN_OFF_MAIN_GAIN;
   assign hit_skew = i_req.addr == SKEW_LOW_ADDR;
   assign o_hit    = hit_aux | hit_main | hit_skew;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      if (i_req.wr) begin
         if (hit_aux) begin
            st_next.aux_gain_reg = i_req.wdata & `PDGAIN_WMASK_GAIN;  // see RL1 see RL7
         end
         if (hit_main) begin
            st_next.main_gain_reg = i_req.wdata & `PDGAIN_WMASK_GAIN;  // see RL1 see RL7
         end
         if (hit_skew) begin
            st_next.skew_low_reg = i_req.wdata;  // see RL5
         end
      end
      if (i_req.rd) begin
         case (1'b1)
            hit_aux:  st_next.rdata_reg = st_reg.aux_gain_reg;
            hit_main: st_next.rdata_reg = st_reg.main_gain_reg;
            hit_skew: st_next.rdata_reg = st_reg.skew_low_reg;
            default:  st_next.rdata_reg = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg.aux_gain_reg  <= `PDGAIN_RST_GAIN;
         st_reg.main_gain_reg <= `PDGAIN_RST_GAIN;
         st_reg.skew_low_reg  <= `PDGAIN_RST_SKEW_LOW;
         st_reg.rdata_reg     <= 8'h00;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rdata      = st_reg.rdata_reg;
   assign o_skew_low   = st_reg.skew_low_reg;
   assign o_aux_field  = to_field(st_reg.aux_gain_reg);
   assign o_main_field = to_field(st_reg.main_gain_reg);

   ////////////////////////////////////////////////////////////////////////////
   // aux loop has no low-rate field of its own; reuse its analog gain
   pdgain_select u_aux_sel (
      .i_field         (o_aux_field),
      .i_mode          (i_aux_mode),
      .i_low_rate_gain (o_aux_field.analog),
      .o_gain          (o_aux_gain),
      .o_gain_valid    (o_aux_gain_valid)
   );

   pdgain_select u_main_sel (
      .i_field         (o_main_field),
      .i_mode          (i_main_mode),
      .i_low_rate_gain (i_main_gain_analog_low_rate),
      .o_gain          (o_main_gain),
      .o_gain_valid    (o_main_gain_valid)
   );

   ////////////////////////////////////////////////////////////////////////////
   property p_aux_write;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.wr && hit_aux) |=> (st_reg.aux_gain_reg == ($past(i_req.wdata) & 8'hF7));
   endproperty
   a_aux_write: assert property (p_aux_write) else $error("aux gain write lost"); // see RL1

   property p_main_write;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.wr && hit_main) |=> (st_reg.main_gain_reg == ($past(i_req.wdata) & 8'hF7));
   endproperty
   a_main_write: assert property (p_main_write) else $error("main gain write lost"); // see RL1

   property p_auto_off;
      @(posedge i_clk) disable iff (!i_rstn)
      (!o_main_field.auto_on && i_main_mode != pdgain_pkg::PDGAIN_LOCK_DIGITAL)
         |-> !o_main_gain_valid;
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("auto gain used while off"); // see RL2

   property p_analog_hi;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_aux_mode == pdgain_pkg::PDGAIN_LOCK_ANALOG_HI && st_reg.aux_gain_reg[7])
         |-> (o_aux_gain_valid && o_aux_gain == st_reg.aux_gain_reg[6:4]);
   endproperty
   a_analog_hi: assert property (p_analog_hi) else $error("analog gain wrong"); // see RL3

   property p_digital;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_main_mode == pdgain_pkg::PDGAIN_LOCK_DIGITAL)
         |-> (o_main_gain_valid && o_main_gain == st_reg.main_gain_reg[2:0]);
   endproperty
   a_digital: assert property (p_digital) else $error("digital gain wrong"); // see RL4

   property p_skew;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.wr && hit_skew) ##1 (!i_req.wr) |-> ##1 (o_skew_low == $past(i_req.wdata, 2));
   endproperty
   a_skew: assert property (p_skew) else $error("skew low byte not held"); // see RL5

   property p_low_rate;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_main_mode == pdgain_pkg::PDGAIN_LOCK_ANALOG_LOW)
         |-> (o_main_gain == i_main_gain_analog_low_rate
              && o_main_gain_valid == st_reg.main_gain_reg[7]);
   endproperty
   a_low_rate: assert property (p_low_rate) else $error("low-rate gain wrong"); // see RL6

   property p_bit3;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.rd && (hit_aux || hit_main)) |=> (o_rdata[3] == 1'b0);
   endproperty
   a_bit3: assert property (p_bit3) else $error("unused bit reads one"); // see RL7

endmodule : pdgain_bank

/* File: verification/tb_dpll_phase_detector_gain_config.sv */
// Purpose: self-checking bench for the second detector gain bank
// Assumes: one-cycle read latency, unmapped reads return zero
// Notes: expectations queued by the driver, compared by the monitor
`timescale 1ns/1ps
`include "pdgain_consts.svh"
module tb_dpll_phase_detector_gain_config;
   logic                      i_clk;
   logic                      i_rstn;
   pdgain_pkg::pdgain_req_s   i_req;
   pdgain_pkg::pdgain_mode_e  i_aux_mode;
   pdgain_pkg::pdgain_mode_e  i_main_mode;
   pdgain_pkg::pdgain_gain_t  i_low;
   logic [7:0]                o_rdata;
   logic                      o_hit;
   logic                      o_aux_gain_valid;
   logic                      o_main_gain_valid;
   pdgain_pkg::pdgain_gain_t  o_aux_gain;
   pdgain_pkg::pdgain_gain_t  o_main_gain;
   logic [7:0]                o_skew_low;
   pdgain_pkg::pdgain_field_s aux_field;
   pdgain_pkg::pdgain_field_s main_field;
   int                        n_fail = 0;
   int                        samples_checked = 0;
   logic [7:0]                rq[$];
   logic [7:0]                fq[$];
   logic                      hq[$];
   logic [3:0]                gq[$];
   logic [7:0]                mdl[4];
   logic                      rd_seen = 1'b0;
   logic                      gchk;

   pdgain_bank DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_aux_mode(i_aux_mode),
      .i_main_mode(i_main_mode), .i_main_gain_analog_low_rate(i_low), .o_rdata(o_rdata),
      .o_hit(o_hit), .o_skew_low(o_skew_low), .o_aux_field(aux_field),
      .o_main_field(main_field), .o_aux_gain(o_aux_gain),
      .o_aux_gain_valid(o_aux_gain_valid), .o_main_gain(o_main_gain),
      .o_main_gain_valid(o_main_gain_valid));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp8

   // gain value only matters while in force
   task automatic cmpg(input logic [3:0] got, input logic [3:0] exp);
      cmp8({4'h0, got[3], exp[3] ? got[2:0] : 3'h0}, {4'h0, exp[3], exp[3] ? exp[2:0] : 3'h0});
   endtask : cmpg

   task automatic conclude;
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   function automatic int idx(input logic [6:0] a);
      return a == `PDGAIN_OFF_AUX_GAIN ? 0 : a == `PDGAIN_OFF_MAIN_GAIN ? 1 :
             a == `PDGAIN_OFF_SKEW_LOW ? 2 : 3;
   endfunction : idx

   function automatic logic [3:0] expg(input pdgain_pkg::pdgain_mode_e m, input logic [7:0] r,
                                       input logic [2:0] low);
      case (m)
         pdgain_pkg::PDGAIN_LOCK_DIGITAL:   return {1'b1, r[2:0]};
         pdgain_pkg::PDGAIN_LOCK_ANALOG_HI: return {r[7], r[6:4]};
         default:                           return {r[7], low};
      endcase
   endfunction : expg

   ////////////////////////////////////////////////////////////////////////////////
   // request stands until the next task replaces it, so no signal is set twice in a step
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      gchk = 1'b0;
      hq.push_back(idx(a) != 3);
      if (idx(a) != 3) mdl[idx(a)] = (idx(a) == 2) ? d : (d & `PDGAIN_WMASK_GAIN);
      @(posedge i_clk);
      #1;
   endtask : wr

   task automatic rd(input logic [6:0] a);
      i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      gchk = 1'b0;
      hq.push_back(idx(a) != 3);
      rq.push_back(mdl[idx(a)]);
      @(posedge i_clk);
      #1;
   endtask : rd

   task automatic gain(input pdgain_pkg::pdgain_mode_e am, input pdgain_pkg::pdgain_mode_e mm);
      i_req = '0;
      i_aux_mode = am;
      i_main_mode = mm;
      i_low = 3'($urandom);
      gq.push_back(expg(am, mdl[0], mdl[0][6:4]));
      gq.push_back(expg(mm, mdl[1], i_low));
      fq.push_back(mdl[2]);
      fq.push_back({1'b0, mdl[0][7:4], mdl[0][2:0]});
      fq.push_back({1'b0, mdl[1][7:4], mdl[1][2:0]});
      gchk = 1'b1;
      @(posedge i_clk);
      #1;
   endtask : gain

   task automatic idle;
      i_req = '0;
      gchk = 1'b0;
      @(posedge i_clk);
      #1;
   endtask : idle

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk) begin : mon
      logic r;
      r = rd_seen;
      rd_seen = i_req.rd;
      if (i_req.rd || i_req.wr) cmp8({7'h0, o_hit}, {7'h0, hq.pop_front()});
      if (gchk) begin
         cmpg({o_aux_gain_valid, o_aux_gain}, gq.pop_front());
         cmpg({o_main_gain_valid, o_main_gain}, gq.pop_front());
         cmp8(o_skew_low, fq.pop_front());
         cmp8({1'b0, aux_field}, fq.pop_front());
         cmp8({1'b0, main_field}, fq.pop_front());
      end
      // read data still holds the earlier read until this edge updates it
      if (r) begin
         cmp8(o_rdata, rq.pop_front());
      end
   end

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   initial begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      conclude();
   end

   initial begin
      i_rstn = 1'b0;
      i_req = '0;
      i_aux_mode = pdgain_pkg::PDGAIN_LOCK_DIGITAL;
      i_main_mode = pdgain_pkg::PDGAIN_LOCK_DIGITAL;
      i_low = 3'h0;
      gchk = 1'b0;
      mdl = '{`PDGAIN_RST_GAIN, `PDGAIN_RST_GAIN, `PDGAIN_RST_SKEW_LOW, 8'h00};
      void'($urandom(13));
      repeat (20) @(posedge i_clk);
      #1 i_rstn = 1'b1;
      for (int a = 8'h6C; a < 8'h72; a++) rd(7'(a));
      gain(pdgain_pkg::PDGAIN_LOCK_ANALOG_HI, pdgain_pkg::PDGAIN_LOCK_ANALOG_LOW);
      wr(`PDGAIN_OFF_AUX_GAIN, 8'hFF);
      rd(`PDGAIN_OFF_AUX_GAIN);
      for (int i = 0; i < 6; i++) begin
         wr(`PDGAIN_OFF_AUX_GAIN, {i[0], 7'($urandom)});
         wr(`PDGAIN_OFF_MAIN_GAIN, {~i[0], 7'($urandom)});
         wr(`PDGAIN_OFF_SKEW_LOW, 8'($urandom));
         wr(7'h71, 8'($urandom));
         for (int a = 8'h6C; a < 8'h72; a++) rd(7'(a));
         for (int j = 0; j < 3; j++) begin
            gain(pdgain_pkg::pdgain_mode_e'(j), pdgain_pkg::pdgain_mode_e'(2 - j));
         end
      end
      // mid-run reset brings every register back to its reset value
      idle();
      i_rstn = 1'b0;
      mdl = '{`PDGAIN_RST_GAIN, `PDGAIN_RST_GAIN, `PDGAIN_RST_SKEW_LOW, 8'h00};
      repeat (2) @(posedge i_clk);
      #1 i_rstn = 1'b1;
      for (int a = 8'h6C; a < 8'h72; a++) rd(7'(a));
      gain(pdgain_pkg::PDGAIN_LOCK_ANALOG_HI, pdgain_pkg::PDGAIN_LOCK_DIGITAL);
      idle();
      repeat (3) @(posedge i_clk);
      conclude();
   end
endmodule : tb_dpll_phase_detector_gain_config
